// ==== hdl/vrs_pkg.sv ====
// constants shared by the regulator start-up and fault sequencer
// assumes every analog level arrives as a 13-bit code of 0.25 mV per step
// ****************************************
// Notes on behaviour
// ****************************************
package vrs_pkg;
    // ****************************************
    // code scale and clock
    // ****************************************
    localparam int          VW            = 13;      // width of a voltage code
    localparam int          LSB_UV        = 250;     // microvolts per code step
    localparam int          CLK_PERIOD_PS = 25000;   // 40 MHz
    localparam int          US_CYC        = 1000000 / CLK_PERIOD_PS;
    // ****************************************
    // enable comparator
    // ****************************************
    localparam int          EN_RISE_MV    = 860;
    localparam int          EN_HYST_MV    = 110;
    localparam logic [12:0] EN_RISE  = 13'(EN_RISE_MV * 1000 / LSB_UV);
    localparam logic [12:0] EN_FALL  = 13'((EN_RISE_MV - EN_HYST_MV) * 1000 / LSB_UV);
    // ****************************************
    // soft-start timing
    // ****************************************
    localparam int          DELAY_US      = 100;     // hold before the ramp
    localparam int          RAMP_UV_PER_US = 3250;   // 3.25 mV per microsecond
    localparam logic [12:0] RAMP_STEP = 13'(RAMP_UV_PER_US / LSB_UV);
    localparam logic [6:0]  DELAY_LAST = 7'(DELAY_US - 1);
    localparam logic [5:0]  US_LAST    = 6'(US_CYC - 1);
    // ****************************************
    // fault thresholds
    // ****************************************
    localparam int          UV_SET_MV     = 300;
    localparam int          UV_CLR_MV     = 250;
    localparam int          OV_DONE_MV    = 400;
    localparam logic [13:0] UV_SET   = 14'(UV_SET_MV * 1000 / LSB_UV);
    localparam logic [13:0] UV_CLR   = 14'(UV_CLR_MV * 1000 / LSB_UV);
    localparam logic [12:0] OV_DONE  = 13'(OV_DONE_MV * 1000 / LSB_UV);
    localparam logic [12:0] OV_TRIP  = 13'h1c20;     // absolute trip, 1.8 V
    localparam logic [13:0] PG_OV_OFS = 14'h0320;    // window top, target + 200 mV
    // ****************************************
    // phase counts
    // ****************************************
    localparam logic [2:0]  PH_TWO   = 3'h2;
    localparam logic [2:0]  PH_THREE = 3'h3;
    localparam logic [2:0]  PH_FOUR  = 3'h4;
    typedef enum logic [2:0] {ST_SHUT, ST_DELAY, ST_RAMP, ST_RUN, ST_LATCH} vrs_state_t;
endpackage

// ==== hdl/vrs_sequencer.sv ====
// start-up, soft-start and fault sequencing for a core rail and a north bridge rail
// assumes comparator levels and voltage codes are synchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module vrs_sequencer (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [12:0] en_volt_i,           // enable pin level
    input  wire logic        vcc_por_i,           // bias supply above threshold
    input  wire logic        drv_core_supply_por_i,
    input  wire logic        drv_nb_supply_por_i,
    input  wire logic        mode_select_pin_i,   // high selects serial mode
    input  wire logic        phase3_sense_neg_i,  // high: tied to bias
    input  wire logic        phase4_sense_neg_i,
    input  wire logic        fixed_vid_enable_i,
    input  wire logic        serial_vid_data_i,
    input  wire logic        serial_vid_clock_i,
    input  wire logic [12:0] core_target_pvi_i,   // decoded parallel code
    input  wire logic [12:0] core_target_svi_i,   // decoded from boot code
    input  wire logic [12:0] nb_target_svi_i,
    input  wire logic [12:0] core_fb_i,           // feedback node levels
    input  wire logic [12:0] nb_fb_i,
    input  wire logic [12:0] core_vsense_i,       // differential output voltage
    input  wire logic [12:0] nb_vsense_i,
    input  wire logic        core_oc_i,
    input  wire logic        nb_oc_i,
    output logic             enabled_o,
    output logic             serial_mode_o,
    output logic [2:0]       boot_code_o,
    output logic [2:0]       phase_count_o,
    output logic [12:0]      core_dac_o,
    output logic [12:0]      nb_dac_o,
    output logic             soft_start_o,
    output logic             core_drive_en_o,
    output logic             nb_drive_en_o,
    output logic             core_lower_on_o,
    output logic             nb_lower_on_o,
    output logic             latched_off_o,
    output logic             power_good_out_o
);
    vrs_pkg::vrs_state_t state_ff;
    logic        en_ff, en_d_ff, serial_ff;
    logic [2:0]  boot_ff, phase_ff;
    logic [12:0] core_tgt_ff, nb_tgt_ff, core_ref_ff, nb_ref_ff;
    logic [5:0]  us_cnt_ff;
    logic [6:0]  delay_cnt_ff;
    logic        core_drv_ff, nb_drv_ff, core_lo_ff, nb_lo_ff;
    logic        core_uv_ff, nb_uv_ff, pg_ff;
    logic        por_ok, en_rise, tick, ss_active;
    logic        ov_core, ov_nb, ov_any, oc_any, fault_latch;
    logic [12:0] nxt_core_ref, nxt_nb_ref;

    // ****************************************
    // qualification
    // ****************************************
    // all three supplies must be good; any drop acts as a supply reset
    assign por_ok    = vcc_por_i & drv_core_supply_por_i & drv_nb_supply_por_i;
    assign en_rise   = en_ff & ~en_d_ff;
    assign ss_active = (state_ff == vrs_pkg::ST_DELAY) || (state_ff == vrs_pkg::ST_RAMP);
    assign tick      = ss_active && (us_cnt_ff == vrs_pkg::US_LAST);

    // enable comparator with hysteresis, so a bouncing level cannot chatter
    always_ff @(posedge mclk_i) begin
        if (rst_i || !por_ok) begin
            en_ff   <= 1'b0;
            en_d_ff <= 1'b0;
        end else begin
            if (en_volt_i > vrs_pkg::EN_RISE) begin
                en_ff <= 1'b1;
            end else if (en_volt_i < vrs_pkg::EN_FALL) begin
                en_ff <= 1'b0;
            end
            en_d_ff <= en_ff;
        end
    end

    // mode and serial boot inputs caught once at the enable rise
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            serial_ff <= 1'b0;
            boot_ff   <= 3'h0;
        end else if (en_rise) begin
            serial_ff <= mode_select_pin_i;
            if (mode_select_pin_i) begin
                boot_ff <= {fixed_vid_enable_i, serial_vid_data_i, serial_vid_clock_i};
            end
        end
    end

    // phase detect runs only while shut down, frozen during operation
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            phase_ff <= vrs_pkg::PH_FOUR;
        end else if (state_ff == vrs_pkg::ST_SHUT) begin
            if (phase3_sense_neg_i && phase4_sense_neg_i) begin
                phase_ff <= vrs_pkg::PH_TWO;
            end else if (phase4_sense_neg_i) begin
                phase_ff <= vrs_pkg::PH_THREE;
            end else begin
                phase_ff <= vrs_pkg::PH_FOUR;
            end
        end
    end

    // ****************************************
    // fault detection
    // ****************************************
    // overvoltage needs both the absolute trip and the window top
    assign ov_core = (core_vsense_i > vrs_pkg::OV_TRIP)
                  && ({1'b0, core_vsense_i} > {1'b0, core_tgt_ff} + vrs_pkg::PG_OV_OFS);
    assign ov_nb   = serial_ff && (nb_vsense_i > vrs_pkg::OV_TRIP)
                  && ({1'b0, nb_vsense_i} > {1'b0, nb_tgt_ff} + vrs_pkg::PG_OV_OFS);
    assign ov_any  = ov_core || ov_nb;
    assign oc_any  = (core_oc_i || (serial_ff && nb_oc_i))
                  && (state_ff != vrs_pkg::ST_SHUT) && (state_ff != vrs_pkg::ST_LATCH);
    assign fault_latch = ov_any || oc_any;

    // ****************************************
    // sequencer
    // ****************************************
    // latched off is left only through a supply reset, never by enable
    always_ff @(posedge mclk_i) begin
        if (rst_i || !por_ok) begin
            state_ff <= vrs_pkg::ST_SHUT;
        end else if (fault_latch) begin
            state_ff <= vrs_pkg::ST_LATCH;
        end else begin
            unique case (state_ff)
                vrs_pkg::ST_SHUT: begin
                    // en_d_ff gives the mode latch one cycle to settle
                    if (en_ff && en_d_ff) begin
                        state_ff <= vrs_pkg::ST_DELAY;
                    end
                end
                vrs_pkg::ST_DELAY: begin
                    if (!en_ff) begin
                        state_ff <= vrs_pkg::ST_SHUT;
                    end else if (tick && delay_cnt_ff == vrs_pkg::DELAY_LAST) begin
                        state_ff <= vrs_pkg::ST_RAMP;
                    end
                end
                vrs_pkg::ST_RAMP: begin
                    if (!en_ff) begin
                        state_ff <= vrs_pkg::ST_SHUT;
                    end else if (core_ref_ff == core_tgt_ff && nb_ref_ff == nb_tgt_ff) begin
                        state_ff <= vrs_pkg::ST_RUN;
                    end
                end
                vrs_pkg::ST_RUN: begin
                    if (!en_ff) begin
                        state_ff <= vrs_pkg::ST_SHUT;
                    end
                end
                vrs_pkg::ST_LATCH: begin
                    state_ff <= vrs_pkg::ST_LATCH;
                end
            endcase
        end
    end

    // microsecond divider and delay counter, live only during soft-start
    always_ff @(posedge mclk_i) begin
        if (rst_i || !ss_active) begin
            us_cnt_ff    <= 6'h00;
            delay_cnt_ff <= 7'h00;
        end else begin
            us_cnt_ff <= tick ? 6'h00 : us_cnt_ff + 6'h01;
            if (tick && state_ff == vrs_pkg::ST_DELAY) begin
                delay_cnt_ff <= delay_cnt_ff + 7'h01;
            end
        end
    end

    // ****************************************
    // targets and ramp
    // ****************************************
    // targets load on entry to soft-start and stay put until shutdown
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            core_tgt_ff <= 13'h0000;
            nb_tgt_ff   <= 13'h0000;
        end else if (state_ff == vrs_pkg::ST_SHUT && en_ff && en_d_ff) begin
            core_tgt_ff <= serial_ff ? core_target_svi_i : core_target_pvi_i;
            nb_tgt_ff   <= serial_ff ? nb_target_svi_i : 13'h0000;
        end
    end

    // one step per microsecond, clamped at the target; 14-bit sum avoids wrap
    always_comb begin
        nxt_core_ref = core_ref_ff;
        nxt_nb_ref   = nb_ref_ff;
        if ({1'b0, core_ref_ff} + {1'b0, vrs_pkg::RAMP_STEP} >= {1'b0, core_tgt_ff}) begin
            nxt_core_ref = core_tgt_ff;
        end else begin
            nxt_core_ref = core_ref_ff + vrs_pkg::RAMP_STEP;
        end
        if ({1'b0, nb_ref_ff} + {1'b0, vrs_pkg::RAMP_STEP} >= {1'b0, nb_tgt_ff}) begin
            nxt_nb_ref = nb_tgt_ff;
        end else begin
            nxt_nb_ref = nb_ref_ff + vrs_pkg::RAMP_STEP;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || state_ff == vrs_pkg::ST_SHUT || state_ff == vrs_pkg::ST_DELAY) begin
            core_ref_ff <= 13'h0000;
            nb_ref_ff   <= 13'h0000;
        end else if (state_ff == vrs_pkg::ST_RAMP && tick) begin
            core_ref_ff <= nxt_core_ref;
            nb_ref_ff   <= nxt_nb_ref;
        end
    end

    // ****************************************
    // drive control
    // ****************************************
    // drives stay off while a pre-charged output sits above the reference;
    // once on they stay on, and the run state forces the core drive on, the north bridge drive only in serial mode
    always_ff @(posedge mclk_i) begin
        if (rst_i || state_ff == vrs_pkg::ST_SHUT || state_ff == vrs_pkg::ST_LATCH) begin
            core_drv_ff <= 1'b0;
            nb_drv_ff   <= 1'b0;
        end else if (state_ff == vrs_pkg::ST_RUN) begin
            core_drv_ff <= 1'b1;
            nb_drv_ff   <= serial_ff;
        end else if (state_ff == vrs_pkg::ST_RAMP) begin
            if (core_ref_ff > core_fb_i) begin
                core_drv_ff <= 1'b1;
            end
            if (serial_ff && nb_ref_ff > nb_fb_i) begin
                nb_drv_ff <= 1'b1;
            end
        end
    end

    // overvoltage clamp: set wins, released below 400 mV, rearms each time
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            core_lo_ff <= 1'b0;
            nb_lo_ff   <= 1'b0;
        end else begin
            if (ov_core) begin
                core_lo_ff <= 1'b1;
            end else if (core_vsense_i < vrs_pkg::OV_DONE) begin
                core_lo_ff <= 1'b0;
            end
            if (ov_nb) begin
                nb_lo_ff <= 1'b1;
            end else if (nb_vsense_i < vrs_pkg::OV_DONE) begin
                nb_lo_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // undervoltage and power good
    // ****************************************
    // undervoltage only flags power good, with 50 mV of hysteresis
    always_ff @(posedge mclk_i) begin
        if (rst_i || state_ff != vrs_pkg::ST_RUN) begin
            core_uv_ff <= 1'b0;
            nb_uv_ff   <= 1'b0;
        end else begin
            if ({1'b0, core_vsense_i} + vrs_pkg::UV_SET < {1'b0, core_tgt_ff}) begin
                core_uv_ff <= 1'b1;
            end else if ({1'b0, core_vsense_i} + vrs_pkg::UV_CLR > {1'b0, core_tgt_ff}) begin
                core_uv_ff <= 1'b0;
            end
            if (serial_ff && {1'b0, nb_vsense_i} + vrs_pkg::UV_SET < {1'b0, nb_tgt_ff}) begin
                nb_uv_ff <= 1'b1;
            end else if ({1'b0, nb_vsense_i} + vrs_pkg::UV_CLR > {1'b0, nb_tgt_ff}) begin
                nb_uv_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || !por_ok) begin
            pg_ff <= 1'b0;
        end else begin
            pg_ff <= (state_ff == vrs_pkg::ST_RUN) && en_ff && !fault_latch
                  && !core_uv_ff && !nb_uv_ff;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign enabled_o        = en_ff;
    assign serial_mode_o    = serial_ff;
    assign boot_code_o      = boot_ff;
    assign phase_count_o    = phase_ff;
    assign core_dac_o       = core_ref_ff;
    assign nb_dac_o         = nb_ref_ff;
    assign soft_start_o     = ss_active;
    assign core_drive_en_o  = core_drv_ff && !core_lo_ff;
    assign nb_drive_en_o    = nb_drv_ff && !nb_lo_ff;
    assign core_lower_on_o  = core_lo_ff;
    assign nb_lower_on_o    = nb_lo_ff;
    assign latched_off_o    = (state_ff == vrs_pkg::ST_LATCH);
    assign power_good_out_o = pg_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    chk_shut_no_en: assert property (
        (state_ff == vrs_pkg::ST_SHUT && !en_ff) |=> state_ff == vrs_pkg::ST_SHUT)
        else $error("left shutdown without enable");
    chk_mode_hold: assert property (
        (en_ff && en_d_ff) |=> $stable(serial_ff))
        else $error("mode changed while enabled");
    chk_two_phase: assert property (
        (state_ff == vrs_pkg::ST_SHUT && phase3_sense_neg_i && phase4_sense_neg_i)
        |=> phase_count_o == vrs_pkg::PH_TWO)
        else $error("two-phase not detected");
    chk_nb_parallel: assert property (
        (!serial_ff && state_ff == vrs_pkg::ST_RUN) |-> !nb_drive_en_o && nb_dac_o == 13'h0000)
        else $error("north bridge active in parallel mode");
    chk_delay_len: assert property (
        (state_ff == vrs_pkg::ST_RAMP && $past(state_ff) == vrs_pkg::ST_DELAY)
        |-> $past(delay_cnt_ff) == vrs_pkg::DELAY_LAST && $past(us_cnt_ff) == vrs_pkg::US_LAST)
        else $error("delay period wrong length");
    chk_ramp_step: assert property (
        (state_ff == vrs_pkg::ST_RAMP && tick && !fault_latch && en_ff && por_ok
         && {1'b0, core_ref_ff} + 14'h000d < {1'b0, core_tgt_ff})
        |=> core_dac_o == $past(core_dac_o) + 13'h000d)
        else $error("ramp step wrong");
    chk_pg_low_ss: assert property (
        (state_ff != vrs_pkg::ST_RUN) |=> !power_good_out_o)
        else $error("power good high outside run");
    chk_ov_latch: assert property (
        (ov_any && por_ok) |=> latched_off_o ##1 !power_good_out_o)
        else $error("overvoltage did not latch off");
    chk_latch_hold: assert property (
        (latched_off_o && por_ok && !rst_i) |=> latched_off_o)
        else $error("left latch without supply reset");
    chk_ov_lower: assert property (
        ov_core |=> core_lower_on_o && !core_drive_en_o)
        else $error("lower switch not forced on");
    chk_uv_pg: assert property (
        core_uv_ff |=> !power_good_out_o)
        else $error("power good high under undervoltage");
    chk_por_shut: assert property (
        !por_ok |=> state_ff == vrs_pkg::ST_SHUT && !power_good_out_o)
        else $error("running without supplies");
endmodule // vrs_sequencer
`default_nettype wire

// ==== sim/vrs_rail_model.sv ====
// behavioural rail: power stage, output filter and sense path of one regulator rail
// assumes dac, drive and clamp levels come straight from the sequencer
`timescale 1ns/1ps
`default_nettype none
module vrs_rail_model (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [12:0] dac_i,
    input  wire logic        drive_en_i,
    input  wire logic        lower_on_i,
    input  wire logic        sag_i,      // load step pulls the sense to zero
    input  wire logic        surge_i,    // shorted upper switch, forces overvoltage
    input  wire logic        load_i,     // load a pre-charged level
    input  wire logic [12:0] preset_i,
    output logic [12:0]      fb_o,
    output logic [12:0]      vsense_o
);
    // ****************************************
    // output level
    // ****************************************
    logic [12:0] level_ff;
    // clamp discharges slowly, so the release threshold is really crossed
    always_ff @(posedge mclk_i) begin
        if (rst_i || load_i) begin
            level_ff <= preset_i;
        end else if (surge_i) begin
            level_ff <= 13'h1c84; // shorted switch charges the output high
        end else if (lower_on_i) begin
            level_ff <= (level_ff > 13'h0040) ? level_ff - 13'h0040 : 13'h0000;
        end else if (drive_en_i) begin
            level_ff <= dac_i; // drives off: a pre-charge simply holds
        end
    end
    assign vsense_o = surge_i ? 13'h1c84 : (sag_i ? 13'h0000 : level_ff);
    assign fb_o     = vsense_o;
endmodule // vrs_rail_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the start-up and fault sequencer
// assumes one 40 MHz clock and two behavioural rail models on the far side
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    logic        mclk_i, rst_i, vcc_por_i, drv_core_supply_por_i, drv_nb_supply_por_i;
    logic        mode_select_pin_i, phase3_sense_neg_i, phase4_sense_neg_i;
    logic        fixed_vid_enable_i, serial_vid_data_i, serial_vid_clock_i;
    logic [12:0] en_volt_i, core_target_pvi_i, core_target_svi_i, nb_target_svi_i;
    logic [12:0] core_fb_i, nb_fb_i, core_vsense_i, nb_vsense_i, core_dac_o, nb_dac_o;
    logic        core_oc_i, nb_oc_i, enabled_o, serial_mode_o, soft_start_o;
    logic [2:0]  boot_code_o, phase_count_o, boot_exp;
    logic        core_drive_en_o, nb_drive_en_o, core_lower_on_o, nb_lower_on_o;
    logic        latched_off_o, power_good_out_o, pg_last, pg_exp;
    logic        core_sag, core_surge, core_load;
    logic [12:0] core_pre;
    logic [1:0]  ph_pins [3] = '{2'h3, 2'h1, 2'h0};
    logic [2:0]  ph_cnt [3]  = '{vrs_pkg::PH_TWO, vrs_pkg::PH_THREE, vrs_pkg::PH_FOUR};
    logic        pg_q [$];
    int          n_errors = 0, checks = 0, i;
    int unsigned rnd;
    // ****************************************
    // design and far side
    // ****************************************
    vrs_sequencer dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .en_volt_i(en_volt_i),
        .vcc_por_i(vcc_por_i), .drv_core_supply_por_i(drv_core_supply_por_i),
        .drv_nb_supply_por_i(drv_nb_supply_por_i), .mode_select_pin_i(mode_select_pin_i),
        .phase3_sense_neg_i(phase3_sense_neg_i), .phase4_sense_neg_i(phase4_sense_neg_i),
        .fixed_vid_enable_i(fixed_vid_enable_i), .serial_vid_data_i(serial_vid_data_i),
        .serial_vid_clock_i(serial_vid_clock_i), .core_target_pvi_i(core_target_pvi_i),
        .core_target_svi_i(core_target_svi_i), .nb_target_svi_i(nb_target_svi_i),
        .core_fb_i(core_fb_i), .nb_fb_i(nb_fb_i), .core_vsense_i(core_vsense_i),
        .nb_vsense_i(nb_vsense_i), .core_oc_i(core_oc_i), .nb_oc_i(nb_oc_i),
        .enabled_o(enabled_o), .serial_mode_o(serial_mode_o), .boot_code_o(boot_code_o),
        .phase_count_o(phase_count_o), .core_dac_o(core_dac_o), .nb_dac_o(nb_dac_o),
        .soft_start_o(soft_start_o), .core_drive_en_o(core_drive_en_o),
        .nb_drive_en_o(nb_drive_en_o), .core_lower_on_o(core_lower_on_o),
        .nb_lower_on_o(nb_lower_on_o), .latched_off_o(latched_off_o),
        .power_good_out_o(power_good_out_o));
    vrs_rail_model core_u (.mclk_i(mclk_i), .rst_i(rst_i), .dac_i(core_dac_o),
        .drive_en_i(core_drive_en_o), .lower_on_i(core_lower_on_o), .sag_i(core_sag),
        .surge_i(core_surge), .load_i(core_load), .preset_i(core_pre),
        .fb_o(core_fb_i), .vsense_o(core_vsense_i));
    // both rails share sag, surge and pre-charge stimulus
    vrs_rail_model nb_u (.mclk_i(mclk_i), .rst_i(rst_i), .dac_i(nb_dac_o),
        .drive_en_i(nb_drive_en_o), .lower_on_i(nb_lower_on_o), .sag_i(core_sag),
        .surge_i(core_surge), .load_i(core_load), .preset_i(core_pre), .fb_o(nb_fb_i),
        .vsense_o(nb_vsense_i));
    // ****************************************
    // clock, watchdog, power good monitor
    // ****************************************
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    // span is about two and a half times the two start-ups plus fault handling
    initial begin
        repeat (40000) @(posedge mclk_i);
        n_errors++;
        final_report();
    end
    // every edge of power good must match the oldest expectation
    initial pg_last = 1'b0;
    always @(posedge mclk_i) begin
        if (!rst_i && power_good_out_o !== pg_last) begin
            pg_exp = (pg_q.size() > 0) ? pg_q.pop_front() : ~power_good_out_o;
            `CHK("power_good_out_o", pg_exp, power_good_out_o)
            pg_last = power_good_out_o;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // enable, then follow delay, ramp and the end of soft-start
    task automatic start_up(input logic [12:0] tgt, input logic pre);
        int n;
        en_volt_i = 13'h0d71;
        n = 0;
        while (soft_start_o !== 1'b1 && n < 10) begin tick(1); n++; end
        `CHK("soft_start_o", 1'b1, soft_start_o)
        tick(3990);
        `CHK("core_dac_o", 13'h0000, core_dac_o)
        n = 0;
        while (core_dac_o === 13'h0000 && n < 60) begin tick(1); n++; end
        `CHK("core_dac_o", 13'h000d, core_dac_o)
        tick(40);
        `CHK("core_dac_o", 13'h001a, core_dac_o)
        tick(400);
        `CHK("core_drive_en_o", ~pre, core_drive_en_o)
        `CHK("power_good_out_o", 1'b0, power_good_out_o)
        n = 0;
        while (soft_start_o === 1'b1 && n < 5000) begin tick(1); n++; end
        `CHK("core_dac_o", tgt, core_dac_o)
        tick(3);
        `CHK("core_drive_en_o", 1'b1, core_drive_en_o)
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_i = 1'b1;
        en_volt_i = 13'h0000;
        {vcc_por_i, drv_core_supply_por_i, drv_nb_supply_por_i} = 3'h7;
        {mode_select_pin_i, phase3_sense_neg_i, phase4_sense_neg_i} = 3'h0;
        {fixed_vid_enable_i, serial_vid_data_i, serial_vid_clock_i} = 3'h0;
        {core_oc_i, nb_oc_i, core_sag, core_surge, core_load} = 5'h00;
        core_target_pvi_i = 13'h0514;
        core_target_svi_i = 13'h0514;
        nb_target_svi_i = 13'h028a;
        core_pre = 13'h0000;
        rnd = $urandom(82706);
        tick(10);
        `CHK("phase_count_o", 3'h4, phase_count_o)
        rst_i = 1'b0;
        for (i = 0; i < 3; i++) begin
            {phase3_sense_neg_i, phase4_sense_neg_i} = ph_pins[i];
            tick(3);
            `CHK("phase_count_o", ph_cnt[i], phase_count_o)
        end
        en_volt_i = 13'h0d70; // exactly the threshold is not above it
        tick(5);
        `CHK("enabled_o", 1'b0, enabled_o)
        en_volt_i = 13'h0d71;
        drv_nb_supply_por_i = 1'b0;
        tick(5);
        `CHK("enabled_o", 1'b0, enabled_o)
        en_volt_i = 13'h0000;
        drv_nb_supply_por_i = 1'b1;
        tick(3);
        // serial start with random boot inputs
        rnd = $urandom;
        boot_exp = rnd[2:0];
        core_target_pvi_i = {5'h04, rnd[10:3]}; // random parallel target, under the pre-charge
        {fixed_vid_enable_i, serial_vid_data_i, serial_vid_clock_i} = boot_exp;
        mode_select_pin_i = 1'b1;
        pg_q.push_back(1'b1);
        start_up(13'h0514, 1'b0);
        {fixed_vid_enable_i, serial_vid_data_i, serial_vid_clock_i} = ~boot_exp;
        mode_select_pin_i = 1'b0;
        tick(3);
        `CHK("boot_code_o", boot_exp, boot_code_o)
        `CHK("serial_mode_o", 1'b1, serial_mode_o)
        // undervoltage dip only touches power good
        pg_q.push_back(1'b0);
        pg_q.push_back(1'b1);
        core_sag = 1'b1;
        tick(5);
        `CHK("latched_off_o", 1'b0, latched_off_o)
        core_sag = 1'b0;
        tick(5);
        en_volt_i = 13'h0c80; // inside the hysteresis band
        tick(5);
        `CHK("enabled_o", 1'b1, enabled_o)
        // overvoltage, release and recurrence
        pg_q.push_back(1'b0);
        core_surge = 1'b1;
        tick(3);
        `CHK("latched_off_o", 1'b1, latched_off_o)
        `CHK("core_lower_on_o", 1'b1, core_lower_on_o)
        `CHK("core_drive_en_o", 1'b0, core_drive_en_o)
        `CHK("nb_lower_on_o", 1'b1, nb_lower_on_o)
        core_surge = 1'b0;
        tick(20);
        `CHK("core_lower_on_o", 1'b1, core_lower_on_o)
        i = 0;
        while (core_lower_on_o === 1'b1 && i < 100) begin tick(1); i++; end
        `CHK("core_lower_on_o", 1'b0, core_lower_on_o)
        core_surge = 1'b1;
        tick(3);
        `CHK("core_lower_on_o", 1'b1, core_lower_on_o)
        core_surge = 1'b0;
        tick(120); // clamp pulls both rails under the release level
        en_volt_i = 13'h0000;
        tick(3);
        en_volt_i = 13'h0d71;
        tick(10);
        `CHK("soft_start_o", 1'b0, soft_start_o)
        en_volt_i = 13'h0000;
        {vcc_por_i, drv_core_supply_por_i} = 2'h0;
        tick(3);
        {vcc_por_i, drv_core_supply_por_i} = 2'h3;
        tick(3);
        `CHK("latched_off_o", 1'b0, latched_off_o)
        // parallel start into a rail pre-charged above target
        core_pre = 13'h07d0;
        core_load = 1'b1;
        tick(1);
        core_load = 1'b0;
        pg_q.push_back(1'b1);
        start_up(core_target_pvi_i, 1'b1);
        `CHK("serial_mode_o", 1'b0, serial_mode_o)
        `CHK("nb_drive_en_o", 1'b0, nb_drive_en_o)
        `CHK("nb_dac_o", 13'h0000, nb_dac_o)
        tick(3);
        pg_q.push_back(1'b0);
        en_volt_i = 13'h0bb7;
        tick(5);
        `CHK("enabled_o", 1'b0, enabled_o)
        // overcurrent during the delay period latches off as well
        en_volt_i = 13'h0d71;
        tick(10);
        {core_oc_i, nb_oc_i} = 2'h3;
        tick(2);
        `CHK("latched_off_o", 1'b1, latched_off_o)
        `CHK("pg_q", 0, pg_q.size())
        final_report();
    end
endmodule // tb_top
`default_nettype wire
